// ==== pifr_params.svh ====
// Register offsets, field positions, reset values and bus response codes.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef PIFR_PARAMS_SVH
`define PIFR_PARAMS_SVH
// ---------------------------------------------------------------
// Register byte addresses (printed offset is the index, times four)
// ---------------------------------------------------------------
`define PIFR_IDX_FLAGS_ONE 8'h0c
`define PIFR_IDX_FLAGS_TWO 8'h0d
`define PIFR_IDX_ENABLES_TWO 8'h8d
`define PIFR_IDX_POWER 8'h8e
`define PIFR_ADDR_W 12
`define PIFR_ADDR_FLAGS_ONE 12'h030
`define PIFR_ADDR_FLAGS_TWO 12'h034
`define PIFR_ADDR_ENABLES_TWO 12'h234
`define PIFR_ADDR_POWER 12'h238
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PIFR_BIT_WIDE_OVF 0
`define PIFR_BIT_PERIOD 1
`define PIFR_BIT_CCP1 2
`define PIFR_BIT_SERIAL 3
`define PIFR_BIT_TX_EMPTY 4
`define PIFR_BIT_RX_FULL 5
`define PIFR_BIT_PARALLEL 7
`define PIFR_BIT_CCP2 0
`define PIFR_BIT_CCP2_EN 0
`define PIFR_BIT_BROWNOUT 0
`define PIFR_BIT_POWERON 1
// ---------------------------------------------------------------
// Reset values and bus answers
// ---------------------------------------------------------------
`define PIFR_FLAGS_RESET 8'h00
`define PIFR_RESP_OKAY 2'h0
`define PIFR_RESP_SLVERR 2'h2
`endif

// ==== pifr_flag_bit.sv ====
// One sticky flag bit: hardware set, software write, set wins.
// Assumes set and write strobes are synchronous one-cycle pulses.
`timescale 1ns/1ns
module pifr_flag_bit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Hardware event and software write
  input wire logic set_pulse,
  input wire logic wr_en,
  input wire logic wr_val,
  // Stored flag
  output logic flag_r
);
  // -------------------------------------------------------------
  // Flag storage
  // -------------------------------------------------------------
  // A set in the same cycle as a clearing write must not be lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else if (set_pulse) begin
      flag_r <= 1'b1;
    end else if (wr_en) begin
      flag_r <= wr_val;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    set_pulse |=> flag_r)
    else $error("flag not set after event");
  hold_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!set_pulse && !wr_en) |=> flag_r == $past(flag_r))
    else $error("flag changed without cause");
endmodule

// ==== pifr_pkg.sv ====
// Types for the peripheral flag block.
// Assumes pifr_params.svh is visible on the include path.
package pifr_pkg;
  // Events from the peripherals, each a one-cycle pulse
  typedef struct packed {
    logic parallel_access;
    logic serial_done;
    logic ccp1_event;
    logic ccp2_event;
    logic period_match;
    logic wide_overflow;
  } pifr_events_type;
  // Capture/compare unit mode
  typedef enum logic [1:0] {
    PIFR_MODE_OFF = 2'b00,
    PIFR_MODE_CAPTURE = 2'b01,
    PIFR_MODE_COMPARE = 2'b10,
    PIFR_MODE_PWM = 2'b11
  } pifr_ccp_mode_type;
  // Reset causes presented at power-up or reset
  typedef struct packed {
    logic power_on;
    logic brown_out;
  } pifr_cause_type;
  // Write channel state
  typedef enum logic [1:0] {
    PIFR_WR_IDLE = 2'b00,
    PIFR_WR_RESP = 2'b01
  } pifr_wr_state_type;
endpackage

// ==== pifr_top.sv ====
// Peripheral interrupt flags, enable and reset-cause status registers.
// Assumes events and USART levels are synchronous to aclk; AXI4-Lite slave.
`timescale 1ns/1ns
`include "pifr_params.svh"
module pifr_top #(
  parameter bit HAS_SERIAL = 1'b1,
  parameter bit HAS_PARALLEL = 1'b1,
  parameter bit HAS_BROWNOUT = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset cause, sampled while aresetn is low
  input wire pifr_pkg::pifr_cause_type reset_cause,
  input wire logic brownout_detect_enable,
  // Peripheral events and modes
  input wire pifr_pkg::pifr_events_type events,
  input wire pifr_pkg::pifr_ccp_mode_type ccp1_mode,
  input wire pifr_pkg::pifr_ccp_mode_type ccp2_mode,
  input wire logic rx_buffer_full,
  input wire logic tx_buffer_empty,
  // Flag outputs to the interrupt logic
  output logic [7:0] flags_one_r,
  output logic [7:0] flags_two_r,
  output logic capcomp_two_enable_r,
  // AXI4-Lite write address and data
  input wire logic [`PIFR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`PIFR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pifr_pkg::*;

  // -------------------------------------------------------------
  // Bus write path
  // -------------------------------------------------------------
  logic [`PIFR_ADDR_W-1:0] aw_addr_r;
  logic aw_have_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;
  logic w_have_r;
  logic wr_fire;
  logic wr_sel_one;
  logic wr_sel_two;
  logic wr_sel_en;
  logic wr_sel_pwr;
  logic wr_known;
  pifr_wr_state_type wr_state_r;

  assign wr_fire = aw_have_r && w_have_r && (wr_state_r == PIFR_WR_IDLE);
  assign wr_sel_one = wr_fire && w_lane0_r &&
                      (aw_addr_r == `PIFR_ADDR_FLAGS_ONE);
  assign wr_sel_two = wr_fire && w_lane0_r &&
                      (aw_addr_r == `PIFR_ADDR_FLAGS_TWO);
  assign wr_sel_en = wr_fire && w_lane0_r &&
                     (aw_addr_r == `PIFR_ADDR_ENABLES_TWO);
  assign wr_sel_pwr = wr_fire && w_lane0_r &&
                      (aw_addr_r == `PIFR_ADDR_POWER);
  assign wr_known = (aw_addr_r == `PIFR_ADDR_FLAGS_ONE) ||
                    (aw_addr_r == `PIFR_ADDR_FLAGS_TWO) ||
                    (aw_addr_r == `PIFR_ADDR_ENABLES_TWO) ||
                    (aw_addr_r == `PIFR_ADDR_POWER);

  // Address and data are taken in either order and held until used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && (wr_state_r == PIFR_WR_IDLE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_lane0_r <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_r && (wr_state_r == PIFR_WR_IDLE);
    end
  end

  // Response: unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= PIFR_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PIFR_RESP_OKAY;
    end else begin
      case (wr_state_r)
        PIFR_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_r <= PIFR_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `PIFR_RESP_OKAY : `PIFR_RESP_SLVERR;
          end
        end
        PIFR_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= PIFR_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_r <= PIFR_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Flag bits
  // -------------------------------------------------------------
  // PWM mode never raises a capture/compare flag
  logic ccp1_set;
  logic ccp2_set;
  logic [7:0] sw_set;
  logic [7:0] sw_en;
  logic [7:0] sw_q;
  logic ccp2_q;
  logic enable_two_r;

  assign ccp1_set = events.ccp1_event && (ccp1_mode == PIFR_MODE_CAPTURE ||
                    ccp1_mode == PIFR_MODE_COMPARE);
  assign ccp2_set = events.ccp2_event && (ccp2_mode == PIFR_MODE_CAPTURE ||
                    ccp2_mode == PIFR_MODE_COMPARE);
  assign sw_set = {events.parallel_access && HAS_PARALLEL, 1'b0, 2'b00,
                   events.serial_done, ccp1_set, events.period_match,
                   events.wide_overflow};
  // Bit 6 is reserved, bits 5 and 4 follow the USART directly
  assign sw_en = {HAS_PARALLEL, 1'b0, 2'b00, 4'hf} &
                 {8{wr_sel_one}};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      pifr_flag_bit u_bit (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_pulse(sw_set[gi]),
        .wr_en(sw_en[gi]),
        .wr_val(w_data_r[gi]),
        .flag_r(sw_q[gi])
      );
    end
  endgenerate

  pifr_flag_bit u_ccp2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_pulse(ccp2_set),
    .wr_en(wr_sel_two),
    .wr_val(w_data_r[`PIFR_BIT_CCP2]),
    .flag_r(ccp2_q)
  );

  // Registered views of the flags; USART bits are live levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_one_r <= `PIFR_FLAGS_RESET;
      flags_two_r <= `PIFR_FLAGS_RESET;
    end else begin
      flags_one_r <= sw_q;
      flags_one_r[`PIFR_BIT_RX_FULL] <=
        HAS_SERIAL && rx_buffer_full;
      flags_one_r[`PIFR_BIT_TX_EMPTY] <=
        HAS_SERIAL && tx_buffer_empty;
      flags_two_r <= {7'h00, ccp2_q};
    end
  end

  // Second enable register: one writable bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_two_r <= 1'b0;
      capcomp_two_enable_r <= 1'b0;
    end else begin
      if (wr_sel_en) begin
        enable_two_r <= w_data_r[`PIFR_BIT_CCP2_EN];
      end
      capcomp_two_enable_r <= wr_sel_en ? w_data_r[`PIFR_BIT_CCP2_EN] :
                              enable_two_r;
    end
  end

  // -------------------------------------------------------------
  // Power control status
  // -------------------------------------------------------------
  // Cause bits live through a core reset, so they are caught in the
  // reset cycles by a clocked process, never as an async constant.
  logic poweron_bit_r;
  logic brownout_bit_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      if (reset_cause.power_on) begin
        poweron_bit_r <= 1'b0;
      end
      if (reset_cause.brown_out || reset_cause.power_on) begin
        brownout_bit_r <= 1'b0;
      end
    end else if (wr_sel_pwr) begin
      poweron_bit_r <= w_data_r[`PIFR_BIT_POWERON];
      brownout_bit_r <= w_data_r[`PIFR_BIT_BROWNOUT];
    end
  end

  // -------------------------------------------------------------
  // Bus read path
  // -------------------------------------------------------------
  logic [7:0] rd_byte;
  logic rd_known;

  always_comb begin
    rd_byte = 8'h00;
    rd_known = 1'b1;
    case (s_axi_araddr)
      `PIFR_ADDR_FLAGS_ONE: rd_byte = flags_one_r;
      `PIFR_ADDR_FLAGS_TWO: rd_byte = flags_two_r;
      `PIFR_ADDR_ENABLES_TWO: rd_byte = {7'h00, enable_two_r};
      // Brown-out bit reads as stored when HAS_BROWNOUT is set, else only while detection is enabled
      `PIFR_ADDR_POWER: rd_byte = {6'h00, poweron_bit_r,
        brownout_bit_r && (HAS_BROWNOUT || brownout_detect_enable)};
      default: rd_known = 1'b0;
    endcase
  end

  // One read at a time: accept, answer next cycle, hold until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PIFR_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_known ? `PIFR_RESP_OKAY : `PIFR_RESP_SLVERR;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Checks and covers
  // -------------------------------------------------------------
  overflow_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    events.wide_overflow |-> ##2 flags_one_r[`PIFR_BIT_WIDE_OVF])
    else $error("overflow flag missing");
  pwm_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ccp1_mode == PIFR_MODE_PWM && !sw_q[`PIFR_BIT_CCP1] && !sw_en[2])
    |=> !sw_q[`PIFR_BIT_CCP1])
    else $error("ccp1 flag set in pwm mode");
  rx_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 flags_one_r[`PIFR_BIT_RX_FULL] == (HAS_SERIAL &&
    $past(rx_buffer_full)))
    else $error("rx flag does not follow buffer");
  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    flags_one_r[6] == 1'b0 && flags_two_r[7:1] == 7'h00)
    else $error("reserved flag bit set");
  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid ##0 $stable(flags_two_r[7:1]))
    else $error("write not answered");
  enable_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_sel_en |=> capcomp_two_enable_r == $past(w_data_r[0]))
    else $error("enable not stored");
  poweron_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_sel_pwr |=> $stable(poweron_bit_r))
    else $error("power-on bit changed");
  cov_ccp2_c: cover property (@(posedge aclk) ccp2_set ##2 flags_two_r[0]);
  cov_clear_c: cover property (@(posedge aclk) wr_sel_one && !w_data_r[0]);
  cov_race_c: cover property (@(posedge aclk)
    wr_sel_one && sw_set[`PIFR_BIT_WIDE_OVF]);
  cov_pwr_c: cover property (@(posedge aclk) wr_sel_pwr);
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the peripheral flag and reset-status block.
// Assumes pifr_params.svh and pifr_pkg are compiled before this file.
`timescale 1ns/1ns
`include "pifr_params.svh"
module tb_top;
  import pifr_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  localparam logic [11:0] a_one = `PIFR_ADDR_FLAGS_ONE;
  localparam logic [11:0] a_two = `PIFR_ADDR_FLAGS_TWO;
  localparam logic [11:0] a_en2 = `PIFR_ADDR_ENABLES_TWO;
  localparam logic [11:0] a_pwr = `PIFR_ADDR_POWER;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  pifr_cause_type reset_cause = 2'h2;
  logic bod_en = 1'b1;
  pifr_events_type events = '0;
  pifr_ccp_mode_type ccp1_mode = PIFR_MODE_CAPTURE;
  pifr_ccp_mode_type ccp2_mode = PIFR_MODE_CAPTURE;
  logic rx_full = 1'b0;
  logic tx_empty = 1'b0;
  logic [7:0] flags_one;
  logic [7:0] flags_two;
  logic ccp2_en;
  logic [11:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [11:0] ea;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic hit;
  logic [7:0] ev_exp [6] = '{8'h01, 8'h02, 8'h01, 8'h04, 8'h08, 8'h80};

  // 20 MHz clock
  always #25 aclk = ~aclk;

  pifr_top u_pifr_top (
    .aclk(aclk), .aresetn(aresetn), .reset_cause(reset_cause),
    .brownout_detect_enable(bod_en), .events(events),
    .ccp1_mode(ccp1_mode), .ccp2_mode(ccp2_mode),
    .rx_buffer_full(rx_full), .tx_buffer_empty(tx_empty),
    .flags_one_r(flags_one), .flags_two_r(flags_two),
    .capcomp_two_enable_r(ccp2_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles >= 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Bus and stimulus tasks
  // ---------------------------------------------------------------
  // Address and data go out together; each drops once its own ready is seen
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'h1, r);
    check($sformatf("bresp %h", a), {30'h0, `PIFR_RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check($sformatf("rdata %h", a), {24'h0, e}, d);
    check($sformatf("rresp %h", a), {30'h0, `PIFR_RESP_OKAY}, {30'h0, r});
  endtask

  // One-cycle event pulse, then time for it to reach the register
  task automatic fire(input pifr_events_type e);
    @(posedge aclk);
    events <= e;
    @(posedge aclk);
    events <= '0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic do_reset(input pifr_cause_type c);
    @(posedge aclk);
    aresetn <= 1'b0;
    reset_cause <= c;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(a_one, 8'h00);
    rd(a_two, 8'h00);
    rd(a_en2, 8'h00);
    rd(a_pwr, 8'h00);
    // Reset-cause bits across a plain core reset and a brown-out reset
    wr(a_pwr, 8'hff);
    rd(a_pwr, 8'h03);
    do_reset(2'h0);
    rd(a_pwr, 8'h03);
    do_reset(2'h1);
    rd(a_pwr, 8'h02);
    // Each event with its enable off; software clear afterwards
    for (int i = 0; i < 6; i++) begin
      fire(pifr_events_type'(6'h01 << i));
      ea = (i == 2) ? a_two : a_one;
      rd(ea, ev_exp[i]);
      check("flag port", {24'h0, ev_exp[i]},
            {24'h0, (i == 2) ? flags_two : flags_one});
      wr(ea, 8'h00);
      rd(ea, 8'h00);
    end
    // Capture units in every mode: only capture and compare set a flag
    for (int m = 0; m < 4; m++) begin
      @(posedge aclk);
      ccp1_mode <= pifr_ccp_mode_type'(2'(m));
      ccp2_mode <= pifr_ccp_mode_type'(2'(m));
      fire(6'h0c);
      hit = (m == 1 || m == 2);
      rd(a_one, {5'h0, hit, 2'h0});
      rd(a_two, {7'h0, hit});
      wr(a_one, 8'h00);
      wr(a_two, 8'h00);
    end
    // Buffer levels mirror in and ignore software writes
    @(posedge aclk);
    rx_full <= 1'b1;
    rd(a_one, 8'h20);
    @(posedge aclk);
    tx_empty <= 1'b1;
    rd(a_one, 8'h30);
    wr(a_one, 8'h00);
    rd(a_one, 8'h30);
    @(posedge aclk);
    rx_full <= 1'b0;
    tx_empty <= 1'b0;
    rd(a_one, 8'h00);
    // Writable bits hold; level bits 5 and 4 ignore the write
    // Reserved bit 6 is kept clear by software
    wr(a_one, 8'hbf);
    rd(a_one, 8'h8f);
    repeat (8) @(posedge aclk);
    rd(a_one, 8'h8f);
    wr(a_one, 8'h00);
    // Clearing write meets a held overflow event at the update edge
    @(posedge aclk);
    s_axi_awaddr <= a_one;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    events <= 6'h01;
    do @(posedge aclk);
    while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    repeat (2) @(posedge aclk);
    events <= '0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    rd(a_one, 8'h01);
    wr(a_one, 8'h00);
    // Second enable register keeps only bit 0
    rd(a_two, 8'h00);
    wr(a_en2, 8'hff);
    rd(a_en2, 8'h01);
    check("enable port", 32'h1, {31'h0, ccp2_en});
    wr(a_en2, 8'h00);
    rd(a_en2, 8'h00);
    // Strobe off leaves the flag alone; unmapped places answer an error
    axi_write(a_two, 8'h01, 4'h0, resp);
    check("bresp nostrb", {30'h0, `PIFR_RESP_OKAY}, {30'h0, resp});
    rd(a_two, 8'h00);
    axi_write(12'h100, 8'hff, 4'h1, resp);
    check("bresp unmapped", {30'h0, `PIFR_RESP_SLVERR}, {30'h0, resp});
    axi_read(12'h100, rdat, resp);
    check("rdata unmapped", 32'h0, rdat);
    check("rresp unmapped", {30'h0, `PIFR_RESP_SLVERR}, {30'h0, resp});
    // Power-on reset in mid-run clears everything that was set
    fire(6'h3f);
    rd(a_two, 8'h00);
    wr(a_en2, 8'h01);
    do_reset(2'h2);
    rd(a_one, 8'h00);
    rd(a_two, 8'h00);
    rd(a_en2, 8'h00);
    rd(a_pwr, 8'h00);
    stop_test();
  end
endmodule
